// *** logic/cips_pkg.sv ***
// Purpose: Shared constants and types for the init and park sequencer ends.
// Assumes: One 20 MHz clock (mclk) on both ends.
// Notes: Cycle counts are derived from times; least times round up.
`default_nettype none
package cips_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned PARK_FILT_NS = 150;
  localparam int unsigned PARK_LEAD_US = 40;
  // Longest ignored glitch, rounded down (none below one cycle)
  localparam int unsigned PARK_FILT_CYC_RAW = (PARK_FILT_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int unsigned PARK_FILT_CYC = (PARK_FILT_CYC_RAW < 1) ? 1 : PARK_FILT_CYC_RAW;
  // Least hold after a park request, rounded up
  localparam int unsigned PARK_HOLD_CYC = (PARK_LEAD_US * CLK_HZ + 999999) / 1000000;

  // ----------------------------------------
  // Defaults for values not fixed by the hardware
  // ----------------------------------------
  localparam int unsigned LOCK_CYC_DEF = 64;
  localparam int unsigned PARK_CYC_DEF = 400;
  localparam int unsigned CFG_W_DEF = 16;
  localparam int unsigned CMD_W = 8;
  localparam logic [7:0] FLASH_READ_CMD = 8'h03;
  localparam int unsigned CNT_W = 16;

  // ----------------------------------------
  // State types
  // ----------------------------------------
  typedef enum logic [2:0] {DS_RESET, DS_LOCK, DS_LOAD, DS_READY, DS_PARKING, DS_PARKED}
    cips_dev_state_t;
  typedef enum logic [1:0] {HS_OFF, HS_RUN, HS_WARN, HS_CUT} cips_host_state_t;

endpackage : cips_pkg
`default_nettype wire

// *** logic/cips_link_if.sv ***
// Purpose: Pins between the controller and its power monitor and host.
// Assumes: Pull-up on the host interrupt line.
// Notes: Pull-up is resolved here from the output enable.
`timescale 1ns/1ns
`default_nettype none
interface cips_link_if;
  logic sys_rst_low;
  logic mirror_safe_request_n;
  logic host_io_supply;
  logic host_irq_o;
  logic host_irq_oe;
  logic host_irq_line;
  logic illum_select_0;
  logic illum_select_1;
  logic illum_oe;
  logic flash_serial_clock;
  logic flash_serial_out;
  logic flash_select0_n;
  logic flash_oe;
  logic flash_serial_in;

  // ----------------------------------------
  // Pulled-up interrupt wire
  // ----------------------------------------
  assign host_irq_line = host_irq_oe ? host_irq_o : 1'b1;

  modport ctrl (
    input sys_rst_low, mirror_safe_request_n, host_io_supply, flash_serial_in,
    output host_irq_o, host_irq_oe, illum_select_0, illum_select_1, illum_oe,
    output flash_serial_clock, flash_serial_out, flash_select0_n, flash_oe
  );
  modport mon (
    output sys_rst_low, mirror_safe_request_n, host_io_supply,
    input host_irq_line
  );
endinterface : cips_link_if
`default_nettype wire

// *** logic/cips_sync.sv ***
// Purpose: Two-flop synchroniser for a group of level inputs.
// Assumes: Inputs are levels; no pulses shorter than two cycles matter.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ns
`default_nettype none
module cips_sync
  import cips_pkg::*;
#(
  parameter int unsigned WIDTH = 2,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } cips_sync_st_t;

  cips_sync_st_t s_r;
  cips_sync_st_t s_nxt;

  // ----------------------------------------
  // Two stages
  // ----------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.meta = d;
    s_nxt.stable = s_r.meta;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      s_r.meta <= RST_VAL;
      s_r.stable <= RST_VAL;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.stable;
endmodule : cips_sync
`default_nettype wire

// *** logic/cips_device.sv ***
// Purpose: Controller end: reset pin handling, init sequence, fast park.
// Assumes: mclk at 20 MHz; serial flash returns config after a read command.
// Notes: Lock wait and park time are parameters; park must end well inside
//        the hold time that the monitor guarantees.
`timescale 1ns/1ns
`default_nettype none
module cips_device
  import cips_pkg::*;
#(
  parameter int unsigned LOCK_CYC = LOCK_CYC_DEF,
  parameter int unsigned PARK_CYC = PARK_CYC_DEF,
  parameter int unsigned CFG_W = CFG_W_DEF
)
(
  input wire logic mclk,
  input wire logic sys_rst,
  cips_link_if.ctrl link,
  input wire logic [1:0] illum_req,
  output logic init_busy,
  output logic init_done,
  output logic park_busy,
  output logic parked,
  output logic [CFG_W-1:0] cfg_word
);
  localparam int unsigned LOAD_BITS = CMD_W + CFG_W;

  typedef struct packed {
    cips_dev_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] bit_idx;
    logic [3:0] filt_cnt;
    logic park_filt_n;
    logic [CFG_W-1:0] cfg;
    logic irq;
    logic irq_oe;
    logic [1:0] illum;
    logic illum_oe;
    logic sclk;
    logic sdout;
    logic sel_n;
    logic flash_oe;
    logic busy;
    logic done;
    logic pk_busy;
    logic pk_done;
  } cips_dev_st_t;

  cips_dev_st_t s_r;
  cips_dev_st_t s_nxt;
  logic [1:0] sync_q;
  logic rst_low_s;
  logic park_n_s;
  logic in_reset;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Reset pin idles low and park pin idles high until proven otherwise
  cips_sync #(
    .WIDTH(2),
    .RST_VAL(2'h2)
  ) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .d({link.mirror_safe_request_n, link.sys_rst_low}),
    .q(sync_q)
  );
  assign rst_low_s = sync_q[0];
  assign park_n_s = sync_q[1];
  // Pin reset acts only through the synchronised copy
  assign in_reset = ~rst_low_s;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    // Glitch filter: a new level must hold past the filter window
    if (park_n_s != s_r.park_filt_n)
    begin
      if (s_r.filt_cnt >= 4'(PARK_FILT_CYC))
      begin
        s_nxt.park_filt_n = park_n_s;
        s_nxt.filt_cnt = '0;
      end
      else
      begin
        s_nxt.filt_cnt = s_r.filt_cnt + 4'h1;
      end
    end
    else
    begin
      s_nxt.filt_cnt = '0;
    end

    // Host-powered output follows the host supply once out of reset
    s_nxt.irq_oe = ~in_reset & link.host_io_supply;

    if (in_reset)
    begin
      // Inactive levels, tri-state flash and illumination pins
      s_nxt.state = DS_RESET;
      s_nxt.cnt = '0;
      s_nxt.bit_idx = '0;
      s_nxt.irq = 1'b0;
      s_nxt.illum = 2'h0;
      s_nxt.illum_oe = 1'b0;
      s_nxt.sclk = 1'b0;
      s_nxt.sdout = 1'b0;
      s_nxt.sel_n = 1'b1;
      s_nxt.flash_oe = 1'b0;
      s_nxt.busy = 1'b0;
      s_nxt.done = 1'b0;
      s_nxt.pk_busy = 1'b0;
      s_nxt.pk_done = 1'b0;
      s_nxt.park_filt_n = 1'b1;
    end
    else
    begin
      case (s_r.state)
        DS_RESET:
        begin
          // Release: drive flash and illumination pins, raise interrupt, flag init in progress
          s_nxt.irq = 1'b1;
          s_nxt.illum_oe = 1'b1;
          s_nxt.flash_oe = 1'b1;
          s_nxt.busy = 1'b1;
          s_nxt.cnt = '0;
          s_nxt.state = DS_LOCK;
        end
        DS_LOCK:
        begin
          // Wait for the PLL to settle before touching flash
          if (s_r.cnt >= CNT_W'(LOCK_CYC - 1))
          begin
            s_nxt.cnt = '0;
            s_nxt.bit_idx = '0;
            s_nxt.sel_n = 1'b0;
            s_nxt.sdout = FLASH_READ_CMD[CMD_W-1];
            s_nxt.state = DS_LOAD;
          end
          else
          begin
            s_nxt.cnt = s_r.cnt + 1'b1;
          end
        end
        DS_LOAD:
        begin
          // Clock at half rate: data set on low phase, sampled on rise
          if (!s_r.sclk)
          begin
            s_nxt.sclk = 1'b1;
            if (s_r.bit_idx >= CNT_W'(CMD_W))
            begin
              s_nxt.cfg = {s_r.cfg[CFG_W-2:0], link.flash_serial_in};
            end
          end
          else
          begin
            s_nxt.sclk = 1'b0;
            s_nxt.bit_idx = s_r.bit_idx + 1'b1;
            if (s_r.bit_idx + 1'b1 < CNT_W'(CMD_W))
            begin
              s_nxt.sdout = FLASH_READ_CMD[CMD_W - 2 - 32'(s_r.bit_idx)];
            end
            else
            begin
              s_nxt.sdout = 1'b0;
            end
            if (s_r.bit_idx >= CNT_W'(LOAD_BITS - 1))
            begin
              s_nxt.sel_n = 1'b1;
              s_nxt.busy = 1'b0;
              s_nxt.done = 1'b1;
              s_nxt.irq = 1'b0;
              s_nxt.state = DS_READY;
            end
          end
        end
        DS_READY:
        begin
          // Illumination follows the user request while running
          s_nxt.illum = illum_req;
        end
        DS_PARKING:
        begin
          // Lights off, park the array within the guaranteed hold time
          s_nxt.illum = 2'h0;
          if (s_r.cnt >= CNT_W'(PARK_CYC - 1))
          begin
            s_nxt.pk_busy = 1'b0;
            s_nxt.pk_done = 1'b1;
            s_nxt.state = DS_PARKED;
          end
          else
          begin
            s_nxt.cnt = s_r.cnt + 1'b1;
          end
        end
        DS_PARKED:
        begin
          // Stays parked until the next reset
          s_nxt.illum = 2'h0;
        end
        default:
        begin
          s_nxt.state = DS_RESET;
        end
      endcase

      // Filtered park request overrides any running phase
      if (!s_r.park_filt_n && s_r.state != DS_RESET &&
          s_r.state != DS_PARKING && s_r.state != DS_PARKED)
      begin
        s_nxt.state = DS_PARKING;
        s_nxt.cnt = '0;
        s_nxt.illum = 2'h0;
        s_nxt.sel_n = 1'b1;
        s_nxt.sclk = 1'b0;
        s_nxt.busy = 1'b0;
        s_nxt.pk_busy = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      s_r <= '0;
      s_r.state <= DS_RESET;
      s_r.park_filt_n <= 1'b1;
      s_r.sel_n <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs, all from flops
  // ----------------------------------------
  assign link.host_irq_o = s_r.irq;
  assign link.host_irq_oe = s_r.irq_oe;
  assign link.illum_select_0 = s_r.illum[0];
  assign link.illum_select_1 = s_r.illum[1];
  assign link.illum_oe = s_r.illum_oe;
  assign link.flash_serial_clock = s_r.sclk;
  assign link.flash_serial_out = s_r.sdout;
  assign link.flash_select0_n = s_r.sel_n;
  assign link.flash_oe = s_r.flash_oe;
  assign init_busy = s_r.busy;
  assign init_done = s_r.done;
  assign park_busy = s_r.pk_busy;
  assign parked = s_r.pk_done;
  assign cfg_word = s_r.cfg;
endmodule : cips_device
`default_nettype wire

// *** logic/cips_host.sv ***
// Purpose: Far end: power monitor plus host gating of commands.
// Assumes: Supply and clock status arrive as synchronous levels.
// Notes: supply_cut marks when supplies may fall after a park request.
`timescale 1ns/1ns
`default_nettype none
module cips_host
  import cips_pkg::*;
#(
  parameter int unsigned HOLD_CYC = PARK_HOLD_CYC
)
(
  input wire logic mclk,
  input wire logic sys_rst,
  cips_link_if.mon link,
  input wire logic supplies_good,
  input wire logic clock_stable,
  input wire logic power_fail_warn,
  input wire logic io_supply_en,
  output logic cmd_allowed,
  output logic supply_cut
);
  typedef struct packed {
    cips_host_state_t state;
    logic [CNT_W-1:0] cnt;
    logic rst_low;
    logic park_n;
    logic io_on;
    logic seen_high;
    logic ok;
    logic cut;
  } cips_host_st_t;

  cips_host_st_t s_r;
  cips_host_st_t s_nxt;

  // ----------------------------------------
  // Monitor sequence
  // ----------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.io_on = io_supply_en;
    case (s_r.state)
      HS_OFF:
      begin
        // Hold reset low with the park request high until all is stable
        s_nxt.rst_low = 1'b0;
        s_nxt.park_n = 1'b1;
        s_nxt.ok = 1'b0;
        s_nxt.seen_high = 1'b0;
        s_nxt.cut = 1'b0;
        if (supplies_good && clock_stable && s_r.park_n && !power_fail_warn)
        begin
          s_nxt.rst_low = 1'b1;
          s_nxt.state = HS_RUN;
        end
      end
      HS_RUN:
      begin
        // Commands only after the line is seen high then low
        if (link.host_irq_line)
        begin
          s_nxt.seen_high = 1'b1;
        end
        else if (s_r.seen_high)
        begin
          s_nxt.ok = 1'b1;
        end
        if (power_fail_warn)
        begin
          s_nxt.park_n = 1'b0;
          s_nxt.ok = 1'b0;
          s_nxt.cnt = '0;
          s_nxt.state = HS_WARN;
        end
      end
      HS_WARN:
      begin
        // Keep reset released and clock running through the park
        if (s_r.cnt >= CNT_W'(HOLD_CYC - 1))
        begin
          s_nxt.cut = 1'b1;
          s_nxt.rst_low = 1'b0;
          s_nxt.state = HS_CUT;
        end
        else
        begin
          s_nxt.cnt = s_r.cnt + 1'b1;
        end
      end
      HS_CUT:
      begin
        // Restart only when the warning is gone
        if (!power_fail_warn)
        begin
          s_nxt.state = HS_OFF;
        end
      end
      default:
      begin
        s_nxt.state = HS_OFF;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      s_r <= '0;
      s_r.state <= HS_OFF;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs, all from flops
  // ----------------------------------------
  assign link.sys_rst_low = s_r.rst_low;
  assign link.mirror_safe_request_n = s_r.park_n;
  assign link.host_io_supply = s_r.io_on;
  assign cmd_allowed = s_r.ok;
  assign supply_cut = s_r.cut;
endmodule : cips_host
`default_nettype wire

// *** test/cips_chk.sv ***
// Purpose: Timing relations on the link that the controller drives.
// Assumes: Lock count 4 and park count 10, as the bench sets them.
// Notes: Sees interface signals only; the host end is judged by the bench.
`timescale 1ns/1ns
`default_nettype none
module cips_chk
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sys_rst_low,
  input wire logic mirror_safe_request_n,
  input wire logic host_io_supply,
  input wire logic host_irq_o,
  input wire logic host_irq_oe,
  input wire logic illum_select_0,
  input wire logic illum_select_1,
  input wire logic illum_oe,
  input wire logic flash_serial_clock,
  input wire logic flash_select0_n,
  input wire logic flash_oe
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // Pin reset must quiet every enable within three edges
  pin_quiet_a: assert property (!sys_rst_low [*4] |-> !host_irq_oe && !illum_oe && !flash_oe
    && flash_select0_n && !flash_serial_clock) else $error("outputs live in pin reset");
  release_drive_a: assert property ($rose(sys_rst_low) && host_io_supply |-> ##[2:6]
    (host_irq_oe && host_irq_o && illum_oe && flash_oe)) else $error("pins not live after release");
  // Lock wait comes before the flash is selected
  lock_first_a: assert property ($rose(host_irq_oe) && host_irq_o |-> flash_select0_n [*3]
    ##[1:8] !flash_select0_n) else $error("flash load not after lock wait");
  irq_busy_a: assert property (host_irq_oe && host_irq_o && !flash_select0_n |=>
    host_irq_o || flash_select0_n) else $error("interrupt dropped during load");
  irq_done_a: assert property ($rose(flash_select0_n) && $past(host_irq_o) && mirror_safe_request_n
    |-> ##[0:2] (host_irq_oe && !host_irq_o)) else $error("interrupt not low at init end");
  sclk_framed_a: assert property (flash_serial_clock |-> !flash_select0_n && flash_oe)
    else $error("flash clock outside a frame");
  park_dark_a: assert property ($fell(mirror_safe_request_n) && sys_rst_low && host_irq_oe
    |-> ##[6:9] (!illum_select_0 && !illum_select_1 && flash_select0_n)) else $error("no park");
  io_cut_a: assert property (!host_io_supply |-> ##[1:2] !host_irq_oe)
    else $error("interrupt driven without host supply");
endmodule : cips_chk
`default_nettype wire

// *** test/tb_top.sv ***
// Purpose: Bench joining controller and monitor ends, plus a lone controller.
// Assumes: Lock 4, park 10, monitor hold at its full default; flash modelled here.
// Notes: The lone controller takes glitches and pin resets from the bench.
`timescale 1ns/1ns
`default_nettype none
module tb_top import cips_pkg::*;;
  localparam logic [15:0] CFG = 16'ha5c3;
  typedef struct packed {logic [1:0] req; logic [1:0] sel;} cips_row_t;
  cips_row_t rows [4] = '{'{2'h0, 2'h0}, '{2'h1, 2'h1}, '{2'h2, 2'h2}, '{2'h3, 2'h3}};
  logic mclk = 1'b0;
  logic sys_rst, supplies_good, clock_stable, power_fail_warn, io_supply_en;
  logic [1:0] illum_req;
  logic init_busy, init_done, park_busy, parked, cmd_allowed, supply_cut;
  logic f_done, f_busy, f_parked;
  logic irq_hi = 1'b0;
  logic sclk_q = 1'b0;
  logic [15:0] cfg_word;
  logic [7:0] cmd_r;
  int bit_n = 0;
  int err_count = 0;
  int check_count = 0;
  int n;
  time t_warn;
  cips_link_if link();
  cips_link_if link_f();

  // ----------------------------------------
  // Ends, checker, clock
  // ----------------------------------------
  always #25 mclk = ~mclk;
  assign link_f.flash_serial_in = 1'b0;
  cips_device #(.LOCK_CYC(4), .PARK_CYC(10)) cips_device_i (.mclk(mclk), .sys_rst(sys_rst),
    .link(link.ctrl), .illum_req(illum_req), .init_busy(init_busy), .init_done(init_done),
    .park_busy(park_busy), .parked(parked), .cfg_word(cfg_word));
  cips_device #(.LOCK_CYC(4), .PARK_CYC(10)) cips_device_f_i (.mclk(mclk), .sys_rst(sys_rst),
    .link(link_f.ctrl), .illum_req(illum_req), .init_busy(), .init_done(f_done),
    .park_busy(f_busy), .parked(f_parked), .cfg_word());
  cips_host cips_host_i (.mclk(mclk), .sys_rst(sys_rst), .link(link.mon),
    .supplies_good(supplies_good), .clock_stable(clock_stable), .io_supply_en(io_supply_en),
    .power_fail_warn(power_fail_warn), .cmd_allowed(cmd_allowed), .supply_cut(supply_cut));
  cips_chk cips_chk_i (.mclk(mclk), .sys_rst(sys_rst), .sys_rst_low(link.sys_rst_low),
    .mirror_safe_request_n(link.mirror_safe_request_n), .host_io_supply(link.host_io_supply),
    .host_irq_o(link.host_irq_o), .host_irq_oe(link.host_irq_oe), .illum_oe(link.illum_oe),
    .illum_select_0(link.illum_select_0), .illum_select_1(link.illum_select_1),
    .flash_serial_clock(link.flash_serial_clock), .flash_select0_n(link.flash_select0_n),
    .flash_oe(link.flash_oe));

  // Flash: data for each clock rise is set up a half cycle early; outside the config bits data follows the inverted clock
  always @(negedge mclk)
  begin
    sclk_q <= link.flash_serial_clock;
    irq_hi <= irq_hi | (link.host_irq_oe & link.host_irq_o & init_busy);
    if (link.flash_select0_n)
      bit_n = 0;
    else if (link.flash_serial_clock && !sclk_q)
    begin
      if (bit_n < 8)
        cmd_r = {cmd_r[6:0], link.flash_serial_out};
      bit_n = bit_n + 1;
    end
    link.flash_serial_in = (bit_n >= 8 && bit_n < 24) ? CFG[23 - bit_n] : ~sclk_q;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run;
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // A wait that used its whole bound ends the run
  task automatic limit(input int used, input int lim);
    if (used >= lim)
    begin
      err_count++;
      complete_run();
    end
  endtask : limit

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    {sys_rst, supplies_good, clock_stable, power_fail_warn, io_supply_en} = 5'h11;
    {link_f.sys_rst_low, link_f.mirror_safe_request_n, link_f.host_io_supply} = 3'h3;
    illum_req = 2'h0;
    repeat (3) @(negedge mclk);
    check({link.host_irq_oe, link.illum_oe, link.flash_oe, link.flash_select0_n}, 4'h1);
    check(link.host_irq_line, 1'b1);
    sys_rst = 1'b0;
    repeat (10) @(negedge mclk);
    check({link.sys_rst_low, link.host_irq_oe}, 2'h0);
    {supplies_good, clock_stable} = 2'h3;
    // Host must stay gated for the whole init
    for (n = 0; n < 400 && init_done !== 1'b1; n++)
    begin
      check(cmd_allowed, 1'b0);
      @(negedge mclk);
    end
    limit(n, 400);
    check(cmd_r, FLASH_READ_CMD);
    check(cfg_word, CFG);
    check({irq_hi, link.host_irq_line, init_busy, link.illum_oe}, 4'h9);
    repeat (2) @(negedge mclk);
    check(cmd_allowed, 1'b1);
    foreach (rows[i])
    begin
      illum_req = rows[i].req;
      repeat (2) @(negedge mclk);
      check({link.illum_select_1, link.illum_select_0}, rows[i].sel);
    end
    // Host supply loss removes only the interrupt drive
    io_supply_en = 1'b0;
    repeat (3) @(negedge mclk);
    check({link.host_irq_oe, link.illum_oe}, 2'h1);
    io_supply_en = 1'b1;
    repeat (3) @(negedge mclk);
    // Fast park from ready, then supplies cut after the hold
    power_fail_warn = 1'b1;
    t_warn = $time;
    for (n = 0; n < 20 && park_busy !== 1'b1; n++) @(negedge mclk);
    limit(n, 20);
    check({link.illum_select_1, link.illum_select_0, link.flash_select0_n}, 3'h1);
    for (n = 0; n < 40 && parked !== 1'b1; n++) @(negedge mclk);
    limit(n, 40);
    check({park_busy, link.sys_rst_low, supply_cut}, 3'h2);
    for (n = 0; n < 900 && supply_cut !== 1'b1; n++) @(negedge mclk);
    limit(n, 900);
    check(($time - t_warn) >= PARK_LEAD_US * 1000, 1'b1);
    repeat (4) @(negedge mclk);
    check({parked, link.host_irq_oe, link.illum_oe, link.flash_oe}, 4'h0);
    // Lone controller: short glitch ignored, longer request parks
    link_f.sys_rst_low = 1'b1;
    for (n = 0; n < 400 && f_done !== 1'b1; n++) @(negedge mclk);
    limit(n, 400);
    link_f.mirror_safe_request_n = 1'b0;
    repeat (3) @(negedge mclk);
    link_f.mirror_safe_request_n = 1'b1;
    repeat (12) @(negedge mclk);
    check({f_busy, f_parked}, 2'h0);
    link_f.mirror_safe_request_n = 1'b0;
    repeat (4) @(negedge mclk);
    link_f.mirror_safe_request_n = 1'b1;
    for (n = 0; n < 40 && f_parked !== 1'b1; n++) @(negedge mclk);
    limit(n, 40);
    repeat (5) @(negedge mclk);
    check(f_parked, 1'b1);
    link_f.sys_rst_low = 1'b0;
    repeat (4) @(negedge mclk);
    check({f_parked, link_f.host_irq_oe, link_f.illum_oe, link_f.flash_oe}, 4'h0);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
